// ### hdl/pbbc_core.sv
/*
 * Burst boundary control of a two-port PCI bridge: decides where posted
 * and delayed writes are disconnected, when writes are retried, how a
 * forwarded read is classified and where its prefetch stops.
 * Assumes the bus state machines, queues and FIFOs sit on the same clock
 * and drive the i_ strobes for one cycle per event. One read at a time.
 */
// The placing of the registers and the strobed register port were chosen for this implementation.
//
// Function
// - Delayed write takes one data phase, then target disconnect.
// - Posted memory write stops at 4KB, or cache line when bit set.
// - Write-disconnect setting is bit 1 of chip control at 40h.
// - Write-and-invalidate with odd line size stops at 4KB.
// - Write-and-invalidate, line 1-8: stop at line end if FIFO lacks line.
// - Write-and-invalidate, line 16: stop at each 16-DWORD boundary.
// - Accept posted data while room remains; disconnect when buffer fills.
// - New delayed write accepted while a queue entry is free.
// - Fast back-to-back writes forwarded; retried when buffers lack room.
// - Every read is delayed, prefetchable or not.
// - Prefetchable reads drive all byte enables active.
// - Prefetch for read line, read multiple, prefetchable memory reads.
// - Non-prefetchable read fetches one DWORD, disconnects after it.
// - I/O, configuration, downstream non-prefetchable memory reads: no prefetch.
// - Prefetch stops at its boundary or earlier target disconnect.
// - Disconnect on last delivered DWORD; discard leftover data.
// - Flow-through prefetches to 4KB or until FRAME ends.
// - Read and read line: 16-DWORD for size 0/16, else cache line.
// - Read multiple: queue full for size 0/16, else second line.
// - Line size value counts DWORDs per cache line.
`timescale 1ns/10ps

module pbbc_core #(
	parameter int PW_DEPTH = 64,
	parameter int CNT_W    = 11
) (
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	input  wire logic [7:0]        i_reg_addr,
	input  wire logic [31:0]       i_reg_wdata,
	input  wire logic              i_reg_wr,
	input  wire logic              i_reg_rd,
	output logic      [31:0]       o_reg_rdata,
	input  wire logic              i_wr_start,
	input  wire logic [3:0]        i_wr_cmd,
	input  wire logic [31:2]       i_wr_addr,
	input  wire logic              i_wr_beat,
	input  wire logic              i_wr_end,
	input  wire logic [$clog2(PW_DEPTH+1)-1:0] i_pw_free,
	input  wire logic              i_dtq_free,
	input  wire logic              i_dly_cpl,
	output logic                   o_wr_claim,
	output logic                   o_wr_stop,
	output logic                   o_wr_retry,
	output logic                   o_dly_post,
	output logic                   o_fb2b_up,
	output logic                   o_fb2b_dn,
	input  wire logic              i_rd_launch,
	input  wire logic [3:0]        i_rd_cmd,
	input  wire logic [31:2]       i_rd_addr,
	input  wire logic              i_rd_pref_space,
	input  wire logic              i_rd_upstream,
	input  wire logic [3:0]        i_rd_be_n,
	input  wire logic              i_tgt_beat,
	input  wire logic              i_tgt_disc,
	input  wire logic              i_rq_room,
	input  wire logic              i_dlv_beat,
	input  wire logic              i_frame_end,
	output logic                   o_fetch_act,
	output logic                   o_fetch_pref,
	output logic                   o_fetch_last,
	output logic      [3:0]        o_tgt_be_n,
	output logic                   o_dlv_stop,
	output logic                   o_discard
);

	localparam int FW = $clog2(PW_DEPTH+1);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	generate
		if (PW_DEPTH < 2 || CNT_W < A_CNT_MIN())
		begin : g_bad
			$error("pbbc_core: PW_DEPTH below 2 or CNT_W too small");
		end
	endgenerate

	function automatic int A_CNT_MIN();
		return pbbc_pkg::A4K_BITS + 1;
	endfunction

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic       fb2b_cmd;
	logic       fb2b_bctl;
	logic       wdc;
	logic [7:0] lsz;

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			fb2b_cmd  <= pbbc_pkg::FB2B_RST;
			fb2b_bctl <= pbbc_pkg::FB2B_RST;
			wdc       <= pbbc_pkg::WDC_RST;
			lsz       <= pbbc_pkg::LSZ_RST;
		end
		else if (i_reg_wr)
		begin
			if (i_reg_addr == pbbc_pkg::OFS_CMD)
				fb2b_cmd <= i_reg_wdata[pbbc_pkg::CMD_FB2B_BIT];
			if (i_reg_addr == pbbc_pkg::OFS_BCTL)
				fb2b_bctl <= i_reg_wdata[pbbc_pkg::BCTL_FB2B_BIT];
			if (i_reg_addr == pbbc_pkg::OFS_CHIP)
				wdc <= i_reg_wdata[pbbc_pkg::CHIP_WDC_BIT];
			if (i_reg_addr == pbbc_pkg::OFS_LSZ)
				lsz <= i_reg_wdata[7:0];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_fb2b_up <= 1'b0;
			o_fb2b_dn <= 1'b0;
		end
		else
		begin
			o_fb2b_up <= fb2b_cmd;
			o_fb2b_dn <= fb2b_bctl;
		end
	end

	// Line size decode, value in DWORDs
	logic       ls_small;
	logic       ls_16;
	logic       ls_0;
	logic [3:0] lmask;

	always_comb
	begin
		ls_small = (lsz == 8'h01) || (lsz == 8'h02) || (lsz == 8'h04) || (lsz == 8'h08);
		ls_16    = (lsz == 8'h10);
		ls_0     = (lsz == 8'h00);
		lmask    = ls_small ? (lsz[3:0] - 4'h1) : 4'hf;
	end

	// ------------------------------------------------------------
	// Boundary functions
	// ------------------------------------------------------------
	function automatic logic at_4k(input logic [29:0] a);
		return &a[pbbc_pkg::A4K_BITS-1:0];
	endfunction

	function automatic logic at_16(input logic [29:0] a);
		return &a[pbbc_pkg::A16_BITS-1:0];
	endfunction

	// Stop with this data phase; f is free space before taking it
	function automatic logic post_stop(input logic [3:0] c, input logic [29:0] a,
		input logic [FW-1:0] f);
		logic lend;
		logic st;
		lend = ((a[3:0] & lmask) == lmask);
		st   = (f <= FW'(1));
		if (c == pbbc_pkg::C_MW)
			st = st || (wdc ? (ls_small || ls_16 ? lend : at_4k(a)) : at_4k(a));
		else if (ls_16)
			st = st || at_16(a);
		else if (ls_small)
			st = st || (lend && ((f - FW'(1)) < FW'(lsz)));
		else
			st = st || at_4k(a);
		return st;
	endfunction

	function automatic logic pref_last(input logic [3:0] c, input logic [29:0] a,
		input logic fl, input logic ln, input logic room);
		logic lend;
		lend = ((a[3:0] & lmask) == lmask);
		if (fl)
			return at_4k(a);
		if (c == pbbc_pkg::C_MRM)
		begin
			if (ls_small)
				return lend && ln;
			if (ls_0 || ls_16)
				return !room || at_4k(a);
			return at_16(a);
		end
		return ls_small ? lend : at_16(a);
	endfunction

	// ------------------------------------------------------------
	// Write acceptance
	// ------------------------------------------------------------
	pbbc_pkg::pbbc_wst_t wst;
	logic [29:0]         waddr;
	logic [3:0]          wcmd;
	logic                is_post;
	logic                is_dly;

	always_comb
	begin
		is_post = (i_wr_cmd == pbbc_pkg::C_MW) || (i_wr_cmd == pbbc_pkg::C_MWI);
		is_dly  = (i_wr_cmd == pbbc_pkg::C_IO_WR) || (i_wr_cmd == pbbc_pkg::C_CFG_WR);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			wst        <= pbbc_pkg::W_IDLE;
			waddr      <= '0;
			wcmd       <= 4'h0;
			o_wr_claim <= 1'b0;
			o_wr_stop  <= 1'b0;
			o_wr_retry <= 1'b0;
			o_dly_post <= 1'b0;
		end
		else
		begin
			o_wr_retry <= 1'b0;
			o_dly_post <= 1'b0;
			unique case (wst)
				pbbc_pkg::W_IDLE:
				begin
					// Fast back-to-back second cycles arrive here too
					if (i_wr_start && is_post)
					begin
						if (i_pw_free == '0)
							o_wr_retry <= 1'b1;
						else
						begin
							wst        <= pbbc_pkg::W_POST;
							waddr      <= i_wr_addr;
							wcmd       <= i_wr_cmd;
							o_wr_claim <= 1'b1;
							o_wr_stop  <= post_stop(i_wr_cmd, i_wr_addr, i_pw_free);
						end
					end
					else if (i_wr_start && is_dly)
					begin
						if (i_dly_cpl)
						begin
							wst        <= pbbc_pkg::W_DLY;
							o_wr_claim <= 1'b1;
							o_wr_stop  <= 1'b1;
						end
						else
						begin
							o_wr_retry <= 1'b1;
							o_dly_post <= i_dtq_free;
						end
					end
				end
				pbbc_pkg::W_POST:
				begin
					if ((i_wr_beat && o_wr_stop) || i_wr_end)
					begin
						wst        <= pbbc_pkg::W_IDLE;
						o_wr_claim <= 1'b0;
						o_wr_stop  <= 1'b0;
					end
					else if (i_wr_beat)
					begin
						// Free count lags a beat; one word assumed consumed
						waddr     <= waddr + 30'h1;
						o_wr_stop <= post_stop(wcmd, waddr + 30'h1, i_pw_free - FW'(1));
					end
				end
				pbbc_pkg::W_DLY:
				begin
					if (i_wr_beat || i_wr_end)
					begin
						wst        <= pbbc_pkg::W_IDLE;
						o_wr_claim <= 1'b0;
						o_wr_stop  <= 1'b0;
					end
				end
				default:
				begin
					wst        <= pbbc_pkg::W_IDLE;
					o_wr_claim <= 1'b0;
					o_wr_stop  <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read classification and prefetch
	// ------------------------------------------------------------
	pbbc_pkg::pbbc_fst_t fst;
	logic [29:0]         raddr;
	logic [3:0]          rcmd;
	logic                flow;
	logic                line1;
	logic                dlv_on;
	logic [CNT_W-1:0]    n_fet;
	logic [CNT_W-1:0]    n_dlv;
	logic                l_pref;
	logic                l_read;
	logic                lend_r;

	always_comb
	begin
		l_read = (i_rd_cmd == pbbc_pkg::C_IO_RD) || (i_rd_cmd == pbbc_pkg::C_CFG_RD) ||
			(i_rd_cmd == pbbc_pkg::C_MR) || (i_rd_cmd == pbbc_pkg::C_MRM) ||
			(i_rd_cmd == pbbc_pkg::C_MRL);
		l_pref = (i_rd_cmd == pbbc_pkg::C_MRL) || (i_rd_cmd == pbbc_pkg::C_MRM) ||
			((i_rd_cmd == pbbc_pkg::C_MR) && (i_rd_pref_space || i_rd_upstream));
		lend_r = ((raddr[3:0] & lmask) == lmask);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			fst          <= pbbc_pkg::F_IDLE;
			raddr        <= '0;
			rcmd         <= 4'h0;
			flow         <= 1'b0;
			line1        <= 1'b0;
			dlv_on       <= 1'b0;
			n_fet        <= '0;
			n_dlv        <= '0;
			o_fetch_act  <= 1'b0;
			o_fetch_pref <= 1'b0;
			o_fetch_last <= 1'b0;
			o_tgt_be_n   <= pbbc_pkg::BE_ALL_N;
			o_discard    <= 1'b0;
		end
		else
		begin
			o_discard <= 1'b0;
			unique case (fst)
				pbbc_pkg::F_IDLE:
				begin
					if (i_rd_launch && l_read)
					begin
						fst          <= pbbc_pkg::F_RUN;
						raddr        <= i_rd_addr;
						rcmd         <= i_rd_cmd;
						flow         <= 1'b0;
						line1        <= 1'b0;
						dlv_on       <= 1'b0;
						n_fet        <= '0;
						n_dlv        <= '0;
						o_fetch_act  <= 1'b1;
						o_fetch_pref <= l_pref;
						o_tgt_be_n   <= l_pref ? pbbc_pkg::BE_ALL_N : i_rd_be_n;
						o_fetch_last <= !l_pref ||
							pref_last(i_rd_cmd, i_rd_addr, 1'b0, 1'b0, i_rq_room);
					end
				end
				pbbc_pkg::F_RUN:
				begin
					if (i_tgt_beat)
						n_fet <= n_fet + CNT_W'(1);
					// Repeat served while fetching: flow-through
					if (i_dlv_beat)
					begin
						dlv_on <= 1'b1;
						flow   <= o_fetch_pref;
						n_dlv  <= n_dlv + CNT_W'(1);
					end
					if ((i_tgt_beat && o_fetch_last) || i_tgt_disc ||
						(flow && i_frame_end))
					begin
						fst          <= pbbc_pkg::F_DONE;
						o_fetch_act  <= 1'b0;
						o_fetch_last <= 1'b0;
					end
					else if (i_tgt_beat)
					begin
						raddr        <= raddr + 30'h1;
						line1        <= line1 || lend_r;
						o_fetch_last <= pref_last(rcmd, raddr + 30'h1,
							flow || (i_dlv_beat && o_fetch_pref),
							line1 || lend_r, i_rq_room);
					end
					else
						o_fetch_last <= !o_fetch_pref || pref_last(rcmd, raddr,
							flow || (i_dlv_beat && o_fetch_pref), line1, i_rq_room);
					if (flow && i_frame_end)
					begin
						fst       <= pbbc_pkg::F_IDLE;
						o_discard <= 1'b1;
					end
				end
				pbbc_pkg::F_DONE:
				begin
					if (i_dlv_beat)
					begin
						dlv_on <= 1'b1;
						n_dlv  <= n_dlv + CNT_W'(1);
					end
					if (i_dlv_beat && o_dlv_stop)
						fst <= pbbc_pkg::F_IDLE;
					else if (dlv_on && i_frame_end)
					begin
						fst       <= pbbc_pkg::F_IDLE;
						o_discard <= 1'b1;
					end
				end
				default:
					fst <= pbbc_pkg::F_IDLE;
			endcase
		end
	end

	// Disconnect goes with the last buffered DWORD once fetching is over
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			o_dlv_stop <= 1'b0;
		else
			o_dlv_stop <= (fst != pbbc_pkg::F_IDLE) && !(i_dlv_beat && o_dlv_stop) &&
				(!o_fetch_pref || ((fst == pbbc_pkg::F_DONE) &&
				(n_dlv + CNT_W'(i_dlv_beat) + CNT_W'(1) >= n_fet)));
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			o_reg_rdata <= 32'h0;
		else if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				pbbc_pkg::OFS_CMD:
					o_reg_rdata <= 32'(fb2b_cmd) << pbbc_pkg::CMD_FB2B_BIT;
				pbbc_pkg::OFS_BCTL:
					o_reg_rdata <= 32'(fb2b_bctl) << pbbc_pkg::BCTL_FB2B_BIT;
				pbbc_pkg::OFS_CHIP:
					o_reg_rdata <= 32'(wdc) << pbbc_pkg::CHIP_WDC_BIT;
				pbbc_pkg::OFS_LSZ:
					o_reg_rdata <= {24'h0, lsz};
				pbbc_pkg::OFS_STAT:
					o_reg_rdata <= {25'h0, line1, dlv_on, flow, fst, wst};
				default:
					o_reg_rdata <= 32'h0;
			endcase
		end
		else
			o_reg_rdata <= 32'h0;
	end

endmodule

// ### hdl/pbbc_pkg.sv
/*
 * Constants for the burst boundary control of a two-port PCI bridge:
 * register offsets, field positions, reset values, bus commands, states.
 * Assumes byte addresses on an 8-bit register port with 32-bit data.
 */
package pbbc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CMD  = 8'h04;
	localparam logic [7:0] OFS_LSZ  = 8'h0c;
	localparam logic [7:0] OFS_BCTL = 8'h3c;
	localparam logic [7:0] OFS_CHIP = 8'h40;
	localparam logic [7:0] OFS_STAT = 8'h44;

	localparam int CMD_FB2B_BIT  = 9;
	localparam int BCTL_FB2B_BIT = 23;
	localparam int CHIP_WDC_BIT  = 1;

	localparam logic       FB2B_RST = 1'b0;
	localparam logic       WDC_RST  = 1'b0;
	localparam logic [7:0] LSZ_RST  = 8'h00;

	// ------------------------------------------------------------
	// Bus commands
	// ------------------------------------------------------------
	localparam logic [3:0] C_IO_RD  = 4'h2;
	localparam logic [3:0] C_IO_WR  = 4'h3;
	localparam logic [3:0] C_MR     = 4'h6;
	localparam logic [3:0] C_MW     = 4'h7;
	localparam logic [3:0] C_CFG_RD = 4'ha;
	localparam logic [3:0] C_CFG_WR = 4'hb;
	localparam logic [3:0] C_MRM    = 4'hc;
	localparam logic [3:0] C_MRL    = 4'he;
	localparam logic [3:0] C_MWI    = 4'hf;

	// DWORD address bits below a 4KB and a 16-DWORD boundary
	localparam int A4K_BITS = 10;
	localparam int A16_BITS = 4;

	localparam logic [3:0] BE_ALL_N = 4'h0;

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		W_IDLE = 2'b00,
		W_POST = 2'b01,
		W_DLY  = 2'b11
	} pbbc_wst_t;

	typedef enum logic [1:0] {
		F_IDLE = 2'b00,
		F_RUN  = 2'b01,
		F_DONE = 2'b11
	} pbbc_fst_t;

endpackage

// ### tb/pbbc_chk.sv
/*
 * Checker for pbbc_core: write disconnect points, retry and queueing,
 * read classification, byte enables and end of target fetch.
 * Assumes it is bound to pbbc_core and sees only its ports.
 */
`timescale 1ns/10ps
module pbbc_chk #(
	parameter int PW_DEPTH = 64
) (
	input wire logic                          i_clk,
	input wire logic                          i_sys_rst,
	input wire logic                          i_reg_rd,
	input wire logic [31:0]                   o_reg_rdata,
	input wire logic                          i_wr_start,
	input wire logic [3:0]                    i_wr_cmd,
	input wire logic [31:2]                   i_wr_addr,
	input wire logic                          i_wr_beat,
	input wire logic [$clog2(PW_DEPTH+1)-1:0] i_pw_free,
	input wire logic                          i_dtq_free,
	input wire logic                          i_dly_cpl,
	input wire logic                          o_wr_claim,
	input wire logic                          o_wr_stop,
	input wire logic                          o_wr_retry,
	input wire logic                          o_dly_post,
	input wire logic [3:0]                    i_rd_cmd,
	input wire logic [3:0]                    i_rd_be_n,
	input wire logic                          i_tgt_beat,
	input wire logic                          i_tgt_disc,
	input wire logic                          o_fetch_act,
	input wire logic                          o_fetch_pref,
	input wire logic                          o_fetch_last,
	input wire logic [3:0]                    o_tgt_be_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// ------------------------------------------------------------
	// Address of the write data phase now on the bus
	// ------------------------------------------------------------
	logic [31:2] wa;
	logic [3:0]  wc;

	always_ff @(posedge i_clk)
	begin
		if (i_wr_start)
		begin
			wa <= i_wr_addr;
			wc <= i_wr_cmd;
		end
		else if (i_wr_beat)
			wa <= wa + 30'h1;
	end

	sequence s_launch;
		$rose(o_fetch_act);
	endsequence

	sequence s_fetch_end;
		o_fetch_act && i_tgt_beat && (o_fetch_last || i_tgt_disc);
	endsequence

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	mw_4k_a: assert property (o_wr_claim && wc == pbbc_pkg::C_MW && wa[11:2] == 10'h3ff
		|-> o_wr_stop) else $error("no stop at 4KB boundary");
	dly_one_a: assert property ($rose(o_wr_claim) && ($past(i_wr_cmd) == pbbc_pkg::C_IO_WR
		|| $past(i_wr_cmd) == pbbc_pkg::C_CFG_WR) |-> o_wr_stop)
		else $error("delayed write not single phase");
	dly_queue_a: assert property (i_wr_start && !o_wr_claim && i_wr_cmd == pbbc_pkg::C_IO_WR
		&& !i_dly_cpl |=> o_wr_retry && o_dly_post == $past(i_dtq_free))
		else $error("delayed write queueing wrong");
	pw_full_a: assert property (i_wr_start && !o_wr_claim && i_wr_cmd == pbbc_pkg::C_MW
		&& i_pw_free == 0 |=> o_wr_retry && !o_wr_claim) else $error("full buffer not retried");
	pref_be_a: assert property (o_fetch_act && o_fetch_pref |-> o_tgt_be_n == 4'h0)
		else $error("prefetch byte enables not all on");
	npref_one_a: assert property (o_fetch_act && !o_fetch_pref |-> o_fetch_last)
		else $error("non-prefetch fetch longer than one");
	npref_be_a: assert property (s_launch ##0 !o_fetch_pref |-> o_tgt_be_n == $past(i_rd_be_n))
		else $error("byte enables not forwarded");
	io_cfg_a: assert property (s_launch ##0 ($past(i_rd_cmd) == pbbc_pkg::C_IO_RD
		|| $past(i_rd_cmd) == pbbc_pkg::C_CFG_RD) |-> !o_fetch_pref)
		else $error("io or config read prefetched");
	line_pref_a: assert property (s_launch ##0 ($past(i_rd_cmd) == pbbc_pkg::C_MRL
		|| $past(i_rd_cmd) == pbbc_pkg::C_MRM) |-> o_fetch_pref)
		else $error("line or multiple read not prefetched");
	fetch_end_a: assert property (s_fetch_end |=> !o_fetch_act)
		else $error("fetch runs past its end");
endmodule

bind pbbc_core pbbc_chk #(.PW_DEPTH(PW_DEPTH)) u_chk (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
	.i_wr_start(i_wr_start), .i_wr_cmd(i_wr_cmd), .i_wr_addr(i_wr_addr),
	.i_wr_beat(i_wr_beat), .i_pw_free(i_pw_free), .i_dtq_free(i_dtq_free),
	.i_dly_cpl(i_dly_cpl), .o_wr_claim(o_wr_claim), .o_wr_stop(o_wr_stop),
	.o_wr_retry(o_wr_retry), .o_dly_post(o_dly_post), .i_rd_cmd(i_rd_cmd),
	.i_rd_be_n(i_rd_be_n), .i_tgt_beat(i_tgt_beat), .i_tgt_disc(i_tgt_disc),
	.o_fetch_act(o_fetch_act), .o_fetch_pref(o_fetch_pref), .o_fetch_last(o_fetch_last),
	.o_tgt_be_n(o_tgt_be_n));

// ### tb/pbbc_far.sv
/*
 * Target on the far bus of a forwarded read: one DWORD per beat,
 * optionally every other cycle, optionally disconnecting on beat n.
 * Assumes the core's fetch outputs on the same clock.
 */
`timescale 1ns/10ps
module pbbc_far (
	input  wire logic       i_clk,
	input  wire logic       i_fetch_act,
	input  wire logic       i_fetch_last,
	input  wire logic       i_slow,
	input  wire logic [4:0] i_disc_n,
	output logic            o_tgt_beat,
	output logic            o_tgt_disc,
	output logic            o_rq_room
);
	logic [4:0] cnt;
	logic       ph = 1'b0;
	logic       nb;

	// No beat after the last one or after a disconnect
	assign nb = i_fetch_act && !(o_tgt_beat && (i_fetch_last || o_tgt_disc)) && (!i_slow || ph);
	// Read queue runs out of room after ten beats
	assign o_rq_room = cnt < 5'h0a;

	always_ff @(posedge i_clk)
	begin
		ph <= ~ph;
		cnt <= i_fetch_act ? cnt + {4'h0, o_tgt_beat} : 5'h0;
		o_tgt_beat <= nb;
		o_tgt_disc <= nb && i_disc_n != 5'h0 && cnt + {4'h0, o_tgt_beat} + 5'h1 == i_disc_n;
	end
endmodule

// ### tb/tb.sv
/*
 * Self-checking bench for pbbc_core: read table, register port,
 * write disconnect cases, retries and a second reset.
 * Assumes pbbc_far as read target and the checker bound to the core.
 */
`timescale 1ns/10ps
module tb;
	typedef struct {
		logic [3:0]  cmd;
		logic        ps;
		logic        up;
		logic [3:0]  be;
		logic [7:0]  lsz;
		logic [31:2] adr;
		logic        slow;
		logic [4:0]  dc;
		logic        pref;
		int          n;
	} pbbc_row_t;

	logic        i_clk = 0, i_sys_rst = 1, i_reg_wr = 0, i_reg_rd = 0, i_wr_start = 0;
	logic        i_wr_beat = 0, i_wr_end = 0, i_dtq_free = 0, i_dly_cpl = 0, i_rd_launch = 0;
	logic        i_rd_pref_space = 0, i_rd_upstream = 0, i_dlv_beat = 0, slow = 0, i_frame_end = 0;
	logic [7:0]  i_reg_addr = 0;
	logic [31:0] i_reg_wdata = 0, d;
	logic [3:0]  i_wr_cmd = 0, i_rd_cmd = 0, i_rd_be_n = 0;
	logic [31:2] i_wr_addr = 0, i_rd_addr = 0;
	logic [6:0]  i_pw_free = 0;
	logic [4:0]  disc_n = 0;
	logic [31:0] o_reg_rdata;
	logic [3:0]  o_tgt_be_n;
	logic        o_wr_claim, o_wr_stop, o_wr_retry, o_dly_post, o_fb2b_up, o_fb2b_dn;
	logic        o_fetch_act, o_fetch_pref, o_fetch_last, o_dlv_stop, o_discard;
	logic        i_tgt_beat, i_tgt_disc, i_rq_room;
	int          fail_count = 0, checks = 0;

	pbbc_row_t rows[12] = '{
		'{4'h2, 0, 0, 4'ha, 8'h00, 'h10, 0, 0, 0, 1},
		'{4'ha, 0, 0, 4'h5, 8'h00, 'h10, 1, 0, 0, 1},
		'{4'h6, 0, 0, 4'h3, 8'h00, 'h10, 0, 0, 0, 1},
		'{4'h6, 1, 0, 4'h3, 8'h00, 'h0c, 0, 0, 1, 4},
		'{4'h6, 0, 1, 4'h3, 8'h10, 'h3e, 1, 0, 1, 2},
		'{4'he, 0, 0, 4'h3, 8'h00, 'h00, 0, 0, 1, 16},
		'{4'he, 0, 0, 4'h3, 8'h00, 'h00, 1, 3, 1, 3},
		'{4'h6, 1, 0, 4'h3, 8'h04, 'h02, 0, 0, 1, 2},
		'{4'he, 0, 0, 4'h3, 8'h08, 'h03, 0, 0, 1, 5},
		'{4'hc, 0, 0, 4'h3, 8'h04, 'h00, 0, 0, 1, 8},
		'{4'hc, 0, 0, 4'h3, 8'h02, 'h01, 0, 0, 1, 3},
		'{4'hc, 0, 0, 4'h3, 8'h00, 'h00, 0, 0, 1, 12}};

	pbbc_core dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .i_wr_start(i_wr_start), .i_wr_cmd(i_wr_cmd),
		.i_wr_addr(i_wr_addr), .i_wr_beat(i_wr_beat), .i_wr_end(i_wr_end),
		.i_pw_free(i_pw_free), .i_dtq_free(i_dtq_free), .i_dly_cpl(i_dly_cpl),
		.o_wr_claim(o_wr_claim), .o_wr_stop(o_wr_stop), .o_wr_retry(o_wr_retry),
		.o_dly_post(o_dly_post), .o_fb2b_up(o_fb2b_up), .o_fb2b_dn(o_fb2b_dn),
		.i_rd_launch(i_rd_launch), .i_rd_cmd(i_rd_cmd), .i_rd_addr(i_rd_addr),
		.i_rd_pref_space(i_rd_pref_space), .i_rd_upstream(i_rd_upstream),
		.i_rd_be_n(i_rd_be_n), .i_tgt_beat(i_tgt_beat), .i_tgt_disc(i_tgt_disc),
		.i_rq_room(i_rq_room), .i_dlv_beat(i_dlv_beat), .i_frame_end(i_frame_end),
		.o_fetch_act(o_fetch_act), .o_fetch_pref(o_fetch_pref), .o_fetch_last(o_fetch_last),
		.o_tgt_be_n(o_tgt_be_n), .o_dlv_stop(o_dlv_stop), .o_discard(o_discard));

	pbbc_far u_far (.i_clk(i_clk), .i_fetch_act(o_fetch_act), .i_fetch_last(o_fetch_last),
		.i_slow(slow), .i_disc_n(disc_n), .o_tgt_beat(i_tgt_beat), .o_tgt_disc(i_tgt_disc),
		.o_rq_room(i_rq_room));

	initial
	begin
		forever #25 i_clk = ~i_clk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			$display("wrong value %s exp %h got %h", nm, e, g);
			fail_count++;
		end
	endtask

	task end_of_test;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task rw(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_reg_wr <= 1;
		i_reg_addr <= a;
		i_reg_wdata <= v;
		@(posedge i_clk);
		i_reg_wr <= 0;
	endtask

	task rr(input logic [7:0] a);
		@(posedge i_clk);
		i_reg_rd <= 1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_rd <= 0;
		#1;
		d = o_reg_rdata;
	endtask

	// Retry expected when n is zero; st says the last beat carries stop
	task wr(input logic [3:0] c, input logic [31:2] a, input logic [6:0] f,
		input logic cp, input logic dq, input int n, input logic st);
		@(posedge i_clk);
		i_wr_start <= 1;
		i_wr_cmd <= c;
		i_wr_addr <= a;
		i_pw_free <= f;
		i_dly_cpl <= cp;
		i_dtq_free <= dq;
		@(posedge i_clk);
		i_wr_start <= 0;
		i_wr_beat <= n > 0;
		#1;
		chk("claim", n > 0, o_wr_claim);
		chk("retry", n == 0, o_wr_retry);
		chk("post", n == 0 && dq && c != pbbc_pkg::C_MW, o_dly_post);
		for (int k = 0; k < n; k++)
		begin
			if (k > 0)
			begin
				@(posedge i_clk);
				#1;
			end
			chk("stop", st && k == n - 1, o_wr_stop);
		end
		@(posedge i_clk);
		i_wr_beat <= 0;
		i_wr_end <= !st && n > 0;
		@(posedge i_clk);
		i_wr_end <= 0;
		#1;
		chk("claim_end", 0, o_wr_claim);
	endtask

	task rd(input pbbc_row_t r);
		int n;
		rw(pbbc_pkg::OFS_LSZ, {24'h0, r.lsz});
		@(posedge i_clk);
		slow <= r.slow;
		disc_n <= r.dc;
		i_rd_launch <= 1;
		i_rd_cmd <= r.cmd;
		i_rd_addr <= r.adr;
		i_rd_pref_space <= r.ps;
		i_rd_upstream <= r.up;
		i_rd_be_n <= r.be;
		@(posedge i_clk);
		i_rd_launch <= 0;
		#1;
		chk("act", 1, o_fetch_act);
		chk("pref", r.pref, o_fetch_pref);
		chk("be", r.pref ? 4'h0 : r.be, o_tgt_be_n);
		n = 0;
		for (int t = 0; t < 60 && o_fetch_act; t++)
		begin
			n += (i_tgt_beat === 1'b1);
			@(posedge i_clk);
			#1;
		end
		chk("fetched", r.n, n);
		for (int k = 1; k <= r.n; k++)
		begin
			@(posedge i_clk);
			i_dlv_beat <= 1;
			#1;
			chk("dlv_stop", k == r.n, o_dlv_stop);
		end
		@(posedge i_clk);
		i_dlv_beat <= 0;
		repeat (2) @(posedge i_clk);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge i_clk);
		i_sys_rst <= 0;
		#1;
		chk("claim_rst", 0, o_wr_claim);
		rr(pbbc_pkg::OFS_CHIP);
		chk("wdc_rst", 0, d & 32'h2);
		foreach (rows[i])
			rd(rows[i]);
		// Delivery during the fetch turns on flow-through
		@(posedge i_clk);
		i_rd_launch <= 1;
		i_rd_cmd <= pbbc_pkg::C_MRL;
		i_rd_addr <= 'h3e0;
		@(posedge i_clk);
		i_rd_launch <= 0;
		i_dlv_beat <= 1;
		@(posedge i_clk);
		i_dlv_beat <= 0;
		repeat (20) @(posedge i_clk);
		#1;
		chk("flow_act", 1, o_fetch_act);
		@(posedge i_clk);
		i_frame_end <= 1;
		@(posedge i_clk);
		i_frame_end <= 0;
		#1;
		chk("discard", 1, o_discard);
		chk("flow_end", 0, o_fetch_act);
		rw(pbbc_pkg::OFS_CMD, 32'h200);
		rw(pbbc_pkg::OFS_BCTL, 32'h800000);
		rr(8'h80);
		chk("unmapped", 0, d);
		chk("fb2b_up", 1, o_fb2b_up);
		chk("fb2b_dn", 1, o_fb2b_dn);
		wr(pbbc_pkg::C_MW, 'h3fe, 40, 0, 0, 2, 1);
		rw(pbbc_pkg::OFS_CHIP, 32'h2);
		rw(pbbc_pkg::OFS_LSZ, 32'h4);
		rr(pbbc_pkg::OFS_CHIP);
		chk("wdc", 32'h2, d & 32'h2);
		wr(pbbc_pkg::C_MW, 'h401, 40, 0, 0, 3, 1);
		wr(pbbc_pkg::C_MWI, 'h002, 40, 0, 0, 2, 0);
		wr(pbbc_pkg::C_MWI, 'h002, 3, 0, 0, 2, 1);
		rw(pbbc_pkg::OFS_LSZ, 32'h10);
		wr(pbbc_pkg::C_MWI, 'h00e, 40, 0, 0, 2, 1);
		rw(pbbc_pkg::OFS_LSZ, 32'h3);
		wr(pbbc_pkg::C_MWI, 'h3fd, 40, 0, 0, 3, 1);
		wr(pbbc_pkg::C_MW, 'h010, 1, 0, 0, 1, 1);
		wr(pbbc_pkg::C_MW, 'h010, 0, 0, 0, 0, 0);
		wr(pbbc_pkg::C_IO_WR, 'h20, 40, 0, 1, 0, 0);
		wr(pbbc_pkg::C_IO_WR, 'h20, 40, 0, 0, 0, 0);
		wr(pbbc_pkg::C_CFG_WR, 'h20, 40, 1, 1, 1, 1);
		@(posedge i_clk);
		i_sys_rst <= 1;
		@(posedge i_clk);
		i_sys_rst <= 0;
		rr(pbbc_pkg::OFS_CHIP);
		chk("wdc_rst2", 0, d & 32'h2);
		chk("fb2b_rst", 0, o_fb2b_up);
		end_of_test;
	end

	initial
	begin
		#(5000 * 50);
		fail_count++;
		end_of_test;
	end
endmodule
